// ---- design/ldsr_pkg.sv ----
// constants for the live diagnostic status register bank
package ldsr_pkg;
    localparam int unsigned REG_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned N_IN_CH = 2;
    typedef logic [REG_W-1:0] ldsr_byte_t;
    typedef logic [ADDR_W-1:0] ldsr_addr_t;
    // register offsets and reset value
    localparam ldsr_addr_t ADDR_SUMMARY = 8'h3D;
    localparam ldsr_addr_t ADDR_IN1 = 8'h3E;
    localparam ldsr_addr_t ADDR_IN2 = 8'h3F;
    localparam ldsr_byte_t RESET_VAL = 8'h00;
    // channel_fault_summary field positions
    localparam int unsigned SUM_IN1 = 7;
    localparam int unsigned SUM_IN2 = 6;
    localparam int unsigned SUM_OUT1 = 5;
    localparam int unsigned SUM_OUT2 = 4;
    localparam int unsigned SUM_BAT_LOW = 3;
    localparam ldsr_byte_t SUM_RSVD_MASK = 8'h07;
    // input channel status field positions
    localparam int unsigned FLD_OPEN = 7;
    localparam int unsigned FLD_SHORTED = 6;
    localparam int unsigned FLD_POS_GND = 5;
    localparam int unsigned FLD_NEG_GND = 4;
    localparam int unsigned FLD_POS_BIAS = 3;
    localparam int unsigned FLD_NEG_BIAS = 2;
    localparam int unsigned FLD_POS_BAT = 1;
    localparam int unsigned FLD_NEG_BAT = 0;
    // packing of the raw fault vector ahead of the synchroniser
    localparam int unsigned RAW_OUT1 = 16;
    localparam int unsigned RAW_OUT2 = 17;
    localparam int unsigned RAW_BAT_LOW = 18;
    localparam int unsigned RAW_W = 19;
endpackage

// ---- design/ldsr_sts_if.sv ----
// bundle between synchroniser, status core and read port
`timescale 1ns/1ps
interface ldsr_sts_if;
    import ldsr_pkg::*;
    logic [N_IN_CH-1:0][REG_W-1:0] in_flt;
    logic out1_flt;
    logic out2_flt;
    logic bat_low;
    ldsr_byte_t sum_reg;
    ldsr_byte_t in1_reg;
    ldsr_byte_t in2_reg;
    modport sync_mp (output in_flt, output out1_flt, output out2_flt, output bat_low);
    modport core_mp (input in_flt, input out1_flt, input out2_flt, input bat_low,
        output sum_reg, output in1_reg, output in2_reg);
    modport rd_mp (input sum_reg, input in1_reg, input in2_reg);
endinterface

// ---- design/ldsr_sync.sv ----
// two-flop synchronisers for the asynchronous fault detector levels
`timescale 1ns/1ps
module ldsr_sync
    import ldsr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [RAW_W-1:0] raw,
    ldsr_sts_if.sync_mp sts
);
    logic [RAW_W-1:0] synced;

    for (genvar i = 0; i < RAW_W; i++) begin : g_bit
        logic meta_ff;
        logic sync_ff;
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                meta_ff <= 1'b0;
                sync_ff <= 1'b0;
            end else begin
                meta_ff <= raw[i];
                sync_ff <= meta_ff;
            end
        end
        assign synced[i] = sync_ff;
    end

    assign sts.in_flt = synced[N_IN_CH*REG_W-1:0];
    assign sts.out1_flt = synced[RAW_OUT1];
    assign sts.out2_flt = synced[RAW_OUT2];
    assign sts.bat_low = synced[RAW_BAT_LOW];
endmodule // ldsr_sync

// ---- design/ldsr_rd_port.sv ----
// register access port: decode, registered read data, write refusal
`timescale 1ns/1ps
module ldsr_rd_port
    import ldsr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire ldsr_addr_t reg_addr,
    input wire logic reg_wr_en,
    input wire ldsr_byte_t reg_wr_data,
    input wire logic reg_rd_en,
    ldsr_sts_if.rd_mp sts,
    output ldsr_byte_t rd_data_ff,
    output logic rd_hit_ff,
    output logic wr_refused_ff,
    output logic wr_rsvd_err_ff
);
    wire sel_sum = (reg_addr == ADDR_SUMMARY);
    wire sel_in1 = (reg_addr == ADDR_IN1);
    wire sel_in2 = (reg_addr == ADDR_IN2);
    wire sel_any = sel_sum | sel_in1 | sel_in2;
    // unmapped offsets answer zero with no hit
    wire ldsr_byte_t rd_mux = sel_sum ? sts.sum_reg :
                              sel_in1 ? sts.in1_reg :
                              sel_in2 ? sts.in2_reg : RESET_VAL;
    wire rsvd_bad = sel_sum & ((reg_wr_data & SUM_RSVD_MASK) != RESET_VAL);
    ldsr_byte_t nxt_rd_data;
    logic nxt_rd_hit;

    assign nxt_rd_data = reg_rd_en ? rd_mux : rd_data_ff;
    assign nxt_rd_hit = reg_rd_en ? sel_any : rd_hit_ff;

    // reads only sample, never disturb the live bits
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_data_ff <= RESET_VAL;
            rd_hit_ff <= 1'b0;
            wr_refused_ff <= 1'b0;
            wr_rsvd_err_ff <= 1'b0;
        end else begin
            rd_data_ff <= nxt_rd_data; // see RULE_19
            rd_hit_ff <= nxt_rd_hit;
            wr_refused_ff <= reg_wr_en & sel_any; // see RULE_19
            wr_rsvd_err_ff <= reg_wr_en & rsvd_bad; // see RULE_08
        end
    end
endmodule // ldsr_rd_port

// ---- design/ldsr_live_diag_status_regs.sv ----
// live diagnostic status register bank top: summary and input channel faults
`timescale 1ns/1ps

// Function
// RULE_01: three registers at 3D-3F, reset zero
// RULE_02: summary bits follow present conditions live
// RULE_03: summary bit 7: input 1 has fault
// RULE_04: summary bit 6: input 2 has fault
// RULE_05: summary bit 5: output 1 has fault
// RULE_06: summary bit 4: output 2 has fault
// RULE_07: summary bit 3: battery short, battery low
// RULE_08: summary bits 2-0 read zero, write zero
// RULE_09: input 1 bit 7: open input
// RULE_10: input 1 bit 6: pins shorted together
// RULE_11: input 1 bits 5,4: pin shorted ground
// RULE_12: input 1 bits 3,2: pin shorted bias
// RULE_13: input 1 bits 1,0: pin shorted battery
// RULE_14: input 2 at 3F, bit 7 open
// RULE_15: input 2 bit 6: pins shorted together
// RULE_16: input 2 bits 5,4: pin shorted ground
// RULE_17: input 2 bits 3-0: bias, battery shorts
// RULE_18: channel summary bit ORs its status bits
// RULE_19: writes ignored, reads free of side effects
module ldsr_live_diag_status_regs
    import ldsr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic in1_open_det,
    input wire logic in1_pins_shorted,
    input wire logic in1_pos_pin_gnd,
    input wire logic in1_neg_pin_gnd,
    input wire logic in1_pos_pin_bias,
    input wire logic in1_neg_pin_bias,
    input wire logic in1_pos_pin_bat,
    input wire logic in1_neg_pin_bat,
    input wire logic in2_open_det,
    input wire logic in2_pins_shorted,
    input wire logic in2_pos_pin_gnd,
    input wire logic in2_neg_pin_gnd,
    input wire logic in2_pos_pin_bias,
    input wire logic in2_neg_pin_bias,
    input wire logic in2_pos_pin_bat,
    input wire logic in2_neg_pin_bat,
    input wire logic out1_fault,
    input wire logic out2_fault,
    input wire logic bat_low_short,
    input wire ldsr_addr_t reg_addr,
    input wire logic reg_wr_en,
    input wire ldsr_byte_t reg_wr_data,
    input wire logic reg_rd_en,
    output ldsr_byte_t reg_rd_data,
    output logic reg_rd_hit,
    output logic reg_wr_refused,
    output logic reg_wr_rsvd_err
);
    logic [RAW_W-1:0] raw;
    logic [N_IN_CH-1:0][REG_W-1:0] in_live_ff;
    logic [N_IN_CH-1:0][REG_W-1:0] nxt_in_live;
    logic [N_IN_CH-1:0] ch_any;
    ldsr_byte_t sum_ff;
    ldsr_byte_t nxt_sum;

    ldsr_sts_if sts ();

    // input channel 1 fault levels in register bit order
    assign raw[FLD_OPEN] = in1_open_det; // see RULE_09
    assign raw[FLD_SHORTED] = in1_pins_shorted; // see RULE_10
    assign raw[FLD_POS_GND] = in1_pos_pin_gnd; // see RULE_11
    assign raw[FLD_NEG_GND] = in1_neg_pin_gnd; // see RULE_11
    assign raw[FLD_POS_BIAS] = in1_pos_pin_bias; // see RULE_12
    assign raw[FLD_NEG_BIAS] = in1_neg_pin_bias; // see RULE_12
    assign raw[FLD_POS_BAT] = in1_pos_pin_bat; // see RULE_13
    assign raw[FLD_NEG_BAT] = in1_neg_pin_bat; // see RULE_13

    // input channel 2 sits one register width higher
    assign raw[REG_W+FLD_OPEN] = in2_open_det; // see RULE_14
    assign raw[REG_W+FLD_SHORTED] = in2_pins_shorted; // see RULE_15
    assign raw[REG_W+FLD_POS_GND] = in2_pos_pin_gnd; // see RULE_16
    assign raw[REG_W+FLD_NEG_GND] = in2_neg_pin_gnd; // see RULE_16
    assign raw[REG_W+FLD_POS_BIAS] = in2_pos_pin_bias; // see RULE_17
    assign raw[REG_W+FLD_NEG_BIAS] = in2_neg_pin_bias; // see RULE_17
    assign raw[REG_W+FLD_POS_BAT] = in2_pos_pin_bat; // see RULE_17
    assign raw[REG_W+FLD_NEG_BAT] = in2_neg_pin_bat; // see RULE_17

    assign raw[RAW_OUT1] = out1_fault;
    assign raw[RAW_OUT2] = out2_fault;
    assign raw[RAW_BAT_LOW] = bat_low_short;

    // detector levels come from analog blocks, so resynchronise first
    ldsr_sync u_sync (
        .mclk (mclk),
        .rst_n (rst_n),
        .raw (raw),
        .sts (sts.sync_mp)
    );

    // live copy per input channel, plus its any-fault term
    for (genvar c = 0; c < N_IN_CH; c++) begin : g_ch
        assign nxt_in_live[c] = sts.in_flt[c]; // see RULE_02
        assign ch_any[c] = |sts.in_flt[c]; // see RULE_18
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                in_live_ff[c] <= RESET_VAL; // see RULE_01
            end else begin
                in_live_ff[c] <= nxt_in_live[c];
            end
        end
    end

    // summary derives from the same synced sample as the channel
    // registers, so both never disagree in any one cycle
    always_comb begin
        nxt_sum = RESET_VAL; // see RULE_08
        nxt_sum[SUM_IN1] = ch_any[0]; // see RULE_03
        nxt_sum[SUM_IN2] = ch_any[1]; // see RULE_04
        nxt_sum[SUM_OUT1] = sts.out1_flt; // see RULE_05
        nxt_sum[SUM_OUT2] = sts.out2_flt; // see RULE_06
        nxt_sum[SUM_BAT_LOW] = sts.bat_low; // see RULE_07
    end

    // no write path exists: contents only track the detectors
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sum_ff <= RESET_VAL; // see RULE_01
        end else begin
            sum_ff <= nxt_sum; // see RULE_02
        end
    end

    assign sts.sum_reg = sum_ff;
    assign sts.in1_reg = in_live_ff[0];
    assign sts.in2_reg = in_live_ff[1];

    // decode of 3D/3E/3F and the registered answer live here
    ldsr_rd_port u_rd (
        .mclk (mclk),
        .rst_n (rst_n),
        .reg_addr (reg_addr), // see RULE_01
        .reg_wr_en (reg_wr_en),
        .reg_wr_data (reg_wr_data),
        .reg_rd_en (reg_rd_en),
        .sts (sts.rd_mp),
        .rd_data_ff (reg_rd_data),
        .rd_hit_ff (reg_rd_hit),
        .wr_refused_ff (reg_wr_refused),
        .wr_rsvd_err_ff (reg_wr_rsvd_err)
    );
endmodule // ldsr_live_diag_status_regs

// ---- dv/ldsr_props.sv ----
// assertions on the status register bank ports
`timescale 1ns/1ps
module ldsr_props
    import ldsr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic out1_fault,
    input wire logic in1_pos_pin_gnd,
    input wire ldsr_addr_t reg_addr,
    input wire logic reg_wr_en,
    input wire ldsr_byte_t reg_wr_data,
    input wire logic reg_rd_en,
    input wire ldsr_byte_t reg_rd_data,
    input wire logic reg_rd_hit,
    input wire logic reg_wr_refused,
    input wire logic reg_wr_rsvd_err
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    wire logic mapped = reg_addr >= ADDR_SUMMARY && reg_addr <= ADDR_IN2;
    wire logic rd_sum = reg_rd_en && reg_addr == ADDR_SUMMARY;
    wire logic bad_wr = reg_addr == ADDR_SUMMARY && (reg_wr_data & SUM_RSVD_MASK) != RESET_VAL;
    a_read_hit_map: assert property (reg_rd_en |=> reg_rd_hit == $past(mapped))
        else $error("read hit flag wrong");
    a_unmapped_zero: assert property (reg_rd_en && !mapped |=> reg_rd_data == RESET_VAL)
        else $error("unmapped read not zero");
    a_rsvd_read: assert property (rd_sum |=> (reg_rd_data & SUM_RSVD_MASK) == RESET_VAL)
        else $error("reserved summary bits not zero");
    a_wr_refused: assert property (reg_wr_en |=> reg_wr_refused == $past(mapped))
        else $error("write refusal flag wrong");
    a_rsvd_write: assert property (reg_wr_en |=> reg_wr_rsvd_err == $past(bad_wr))
        else $error("reserved write flag wrong");
    a_pulse_idle: assert property (!reg_wr_en |=> !reg_wr_refused && !reg_wr_rsvd_err)
        else $error("write flag without write");
    a_rd_hold: assert property (!reg_rd_en |=> $stable(reg_rd_data) && $stable(reg_rd_hit))
        else $error("read data moved without read");
    a_out1_live: assert property (out1_fault [*4] ##0 rd_sum |=> reg_rd_data[SUM_OUT1])
        else $error("output 1 summary missing");
    a_in1_summary: assert property (in1_pos_pin_gnd [*4] ##0 rd_sum |=> reg_rd_data[SUM_IN1])
        else $error("input 1 summary missing");
    c_sum_read: cover property (rd_sum ##1 reg_rd_data[SUM_IN1]);
    c_refused: cover property (reg_wr_refused);
    c_rsvd_err: cover property (reg_wr_rsvd_err);
endmodule // ldsr_props

// ---- dv/ldsr_live_diag_status_regs_tb.sv ----
// self-checking bench for the status register bank
`timescale 1ns/1ps
module ldsr_live_diag_status_regs_tb import ldsr_pkg::*;;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [18:0] f = 19'h00000;
    ldsr_addr_t reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    ldsr_byte_t reg_wr_data = 8'h00;
    logic reg_rd_en = 1'b0;
    ldsr_byte_t reg_rd_data;
    logic reg_rd_hit;
    logic reg_wr_refused;
    logic reg_wr_rsvd_err;
    int num_errors = 0;
    int comparisons = 0;
    ldsr_live_diag_status_regs dut_u (.mclk, .rst_n,
        .in1_open_det(f[15]), .in1_pins_shorted(f[14]), .in1_pos_pin_gnd(f[13]),
        .in1_neg_pin_gnd(f[12]), .in1_pos_pin_bias(f[11]), .in1_neg_pin_bias(f[10]),
        .in1_pos_pin_bat(f[9]), .in1_neg_pin_bat(f[8]), .in2_open_det(f[7]),
        .in2_pins_shorted(f[6]), .in2_pos_pin_gnd(f[5]), .in2_neg_pin_gnd(f[4]),
        .in2_pos_pin_bias(f[3]), .in2_neg_pin_bias(f[2]), .in2_pos_pin_bat(f[1]),
        .in2_neg_pin_bat(f[0]), .out1_fault(f[16]), .out2_fault(f[17]),
        .bat_low_short(f[18]), .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
        .reg_rd_data, .reg_rd_hit, .reg_wr_refused, .reg_wr_rsvd_err);
    always #10 mclk = ~mclk;
    function automatic ldsr_byte_t expv(input ldsr_addr_t a);
        case (a)
            ADDR_SUMMARY: return {|f[15:8], |f[7:0], f[16], f[17], f[18], 3'h0};
            ADDR_IN1: return f[15:8];
            ADDR_IN2: return f[7:0];
            default: return RESET_VAL;
        endcase
    endfunction
    task automatic chk(input ldsr_byte_t e, input ldsr_byte_t g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd(input ldsr_addr_t a);
        ldsr_byte_t e;
        logic h;
        e = expv(a);
        h = a >= ADDR_SUMMARY && a <= ADDR_IN2;
        @(negedge mclk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd_en = 1'b0;
        chk(e, reg_rd_data);
        chk({7'h00, h}, {7'h00, reg_rd_hit});
    endtask
    task automatic rd_all;
        rd(ADDR_SUMMARY);
        rd(ADDR_IN1);
        rd(ADDR_IN2);
    endtask
    task automatic wr(input ldsr_addr_t a, input ldsr_byte_t d, input logic r, input logic x);
        @(negedge mclk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(negedge mclk);
        reg_wr_en = 1'b0;
        chk({6'h00, r, x}, {6'h00, reg_wr_refused, reg_wr_rsvd_err});
    endtask
    // two idle edges, so the read lands on the fourth rising edge after the change
    task automatic settle(input logic [18:0] v);
        f = v;
        repeat (2) @(negedge mclk);
    endtask
    task automatic t_reset;
        rd_all();
        rd(8'h3C);
        rd(8'h40);
        $display("test reset done");
    endtask
    task automatic t_walk;
        for (int i = 0; i < 19; i++) begin
            settle(19'h00001 << i);
            rd_all();
        end
        settle(19'h7FFFF);
        rd_all();
        settle(19'h00000);
        rd_all();
        $display("test walk done");
    endtask
    task automatic t_write;
        settle(19'h2C3A5);
        wr(ADDR_SUMMARY, 8'hFF, 1'b1, 1'b1);
        wr(ADDR_SUMMARY, 8'h00, 1'b1, 1'b0);
        wr(ADDR_IN1, 8'hFF, 1'b1, 1'b0);
        wr(ADDR_IN2, 8'h5A, 1'b1, 1'b0);
        wr(8'h40, 8'hFF, 1'b0, 1'b0);
        rd_all();
        $display("test write done");
    endtask
    // reset with every fault present: the first read must still see zero
    task automatic t_mid_reset;
        settle(19'h7FFFF);
        rst_n = 1'b0;
        @(negedge mclk);
        rst_n = 1'b1;
        reg_rd_en = 1'b1;
        reg_addr = ADDR_SUMMARY;
        @(negedge mclk);
        reg_rd_en = 1'b0;
        chk(RESET_VAL, reg_rd_data);
        chk(8'h01, {7'h00, reg_rd_hit});
        repeat (2) @(negedge mclk);
        rd_all();
        settle(19'h00000);
        $display("test mid reset done");
    endtask
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_walk();
        t_write();
        t_mid_reset();
        end_of_test();
    end
    // run needs about 220 cycles, so 1000 means a hang
    initial begin
        #20000;
        num_errors++;
        end_of_test();
    end
endmodule // ldsr_live_diag_status_regs_tb
bind ldsr_live_diag_status_regs ldsr_props props_u (.mclk, .rst_n, .out1_fault,
    .in1_pos_pin_gnd, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
    .reg_rd_hit, .reg_wr_refused, .reg_wr_rsvd_err);
